//--- logic/cbt_params.svh
// constants for the bit-timing and synchronization block
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// configuration field, counter and bit-clock widths
`define CBT_BRP_W      6
`define CBT_SEG1_W     5
`define CBT_SEG2_W     4
`define CBT_SJW_W      4
`define CBT_CNT_W      6
`define CBT_CLKS_W     12

// timing: system clock period and the nominal bit period, both in ns
`define CBT_CLK_NS     100
`define CBT_TBIT_NS    4000
`define CBT_NOM_CLKS   (`CBT_TBIT_NS / `CBT_CLK_NS)

// bus levels
`define CBT_RECESSIVE  1'b1
`define CBT_DOMINANT   1'b0

// segment limits in time quanta
`define CBT_SYNC_TQ    6'h01
`define CBT_SEG2_MIN   4'h2
`define CBT_STEP       6'h01

`endif

//--- logic/cbt_pkg.sv
// types shared by the bit-timing and synchronization block
`include "cbt_params.svh"

package cbt_pkg;

   typedef enum logic [1:0] {
      CBT_ST_IDLE = 2'b00,
      CBT_ST_SYNC = 2'b01,
      CBT_ST_SEG1 = 2'b10,
      CBT_ST_SEG2 = 2'b11
   } cbt_state_e;

   typedef enum logic {
      CBT_SMP_SINGLE = 1'b0,
      CBT_SMP_TRIPLE = 1'b1
   } cbt_smode_e;

   typedef struct packed {
      logic [`CBT_BRP_W-1:0]  brp;
      logic [`CBT_SEG1_W-1:0] seg1;
      logic [`CBT_SEG2_W-1:0] seg2;
      logic [`CBT_SJW_W-1:0]  sjw;
      cbt_smode_e             smode;
   } cbt_cfg_s;

endpackage

//--- logic/cbt_tq_div.sv
// time quantum divider: one tick every div+1 system clocks
`timescale 1ns/1ps
`include "cbt_params.svh"

module cbt_tq_div #(
   parameter int W = `CBT_BRP_W
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic         run,
   input  wire logic [W-1:0] div,
   output logic              tick
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb begin
      tick  = run && (cnt_q == div);
      cnt_d = (!run || tick) ? '0 : W'(cnt_q + 1'b1);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

//--- logic/cbt_edge_det.sv
// recessive-to-dominant edge detector, evaluated once per time quantum
`timescale 1ns/1ps
`include "cbt_params.svh"

module cbt_edge_det (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic tick,
   input  wire logic rx,
   output logic      fall,
   output logic      prev_q
);

   logic prev_d;

   always_comb begin
      fall   = tick && (prev_q == `CBT_RECESSIVE) && (rx == `CBT_DOMINANT);
      prev_d = tick ? rx : prev_q;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prev_q <= `CBT_RECESSIVE;
      end else begin
         prev_q <= prev_d;
      end
   end

endmodule

//--- logic/cbt_bit_timing.sv
// bit timing, resynchronization, sampling and transmit bit framing
`timescale 1ns/1ps
`include "cbt_params.svh"

// Functional notes
// RULE1 - bit period is whole system clocks, configurable
// RULE2 - target 4000 ns bit, flag mismatch
// RULE3 - time quantum from programmable clock divider
// RULE4 - each bit starts with one-quantum sync slot
// RULE5 - edge in early segment lengthens it
// RULE6 - early segment merges propagation and first phase
// RULE7 - edge in late segment shortens it
// RULE8 - adjustment never exceeds programmed jump limit
// RULE9 - one sample at early/late segment boundary
// RULE10 - transmit bit held one full bit period
// RULE11 - sample-mode setting selects samples per bit; code always takes one sample and flags a triple request as a config error
// RULE12 - always single sample, triple is refused
// RULE13 - nominal bit must equal 4000 ns
// RULE14 - adjust by min of error and limit
// RULE15 - next sync slot right after late segment
module cbt_bit_timing
   import cbt_pkg::*;
#(
   parameter int CNT_W = `CBT_CNT_W
) (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   enable,
   input  wire cbt_cfg_s               cfg,
   input  wire logic                   tx_bit,
   input  wire logic                   rx_in,
   output logic                        tx_out_q,
   output logic                        rx_bit_q,
   output logic                        sample_q,
   output logic                        bit_start_q,
   output logic                        resync_q,
   output logic [CNT_W-1:0]            phase_err_q,
   output cbt_smode_e                  smode_q,
   output logic [`CBT_CLKS_W-1:0]      bit_clks_q,
   output logic                        rate_ok_q,
   output logic                        cfg_err_q
);

   cbt_state_e             state_q;
   cbt_state_e             state_d;
   logic [CNT_W-1:0]       cnt_q;
   logic [CNT_W-1:0]       cnt_d;
   logic [CNT_W-1:0]       len_q;
   logic [CNT_W-1:0]       len_d;
   logic                   synced_q;
   logic                   synced_d;
   logic                   tx_d;
   logic                   rxb_d;
   logic                   smp_d;
   logic                   bs_d;
   logic                   rs_d;
   logic [CNT_W-1:0]       perr_d;
   cbt_smode_e             smode_d;
   logic [`CBT_CLKS_W-1:0] clks_d;
   logic                   rate_d;
   logic                   cerr_d;

   logic                   tq_tick;
   logic                   rx_fall;
   logic                   rx_prev;

   logic [CNT_W-1:0]       sjw_w;
   logic [CNT_W-1:0]       seg1_w;
   logic [CNT_W-1:0]       seg2_w;
   logic [CNT_W-1:0]       pos;
   logic [CNT_W-1:0]       err;
   logic [CNT_W-1:0]       adj;
   logic [CNT_W-1:0]       rem;

   // quanta are only counted while enabled so the first bit starts cleanly
   cbt_tq_div #(
      .W (`CBT_BRP_W)
   ) u_div (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .run     (enable),
      .div     (cfg.brp),
      .tick    (tq_tick)
   ); // RULE3

   cbt_edge_det u_edge (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .tick    (tq_tick),
      .rx      (rx_in),
      .fall    (rx_fall),
      .prev_q  (rx_prev)
   );

   function automatic logic [CNT_W-1:0] min_q(input logic [CNT_W-1:0] a,
                                              input logic [CNT_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // timing state: segment walk, resync and sampling
   always_comb begin
      sjw_w    = CNT_W'(cfg.sjw);
      seg1_w   = CNT_W'(cfg.seg1);
      seg2_w   = CNT_W'(cfg.seg2);
      pos      = CNT_W'(cnt_q + `CBT_STEP);
      err      = '0;
      adj      = '0;
      rem      = '0;
      state_d  = state_q;
      cnt_d    = cnt_q;
      len_d    = len_q;
      synced_d = synced_q;
      tx_d     = tx_out_q;
      rxb_d    = rx_bit_q;
      smp_d    = 1'b0;
      bs_d     = 1'b0;
      rs_d     = 1'b0;
      perr_d   = phase_err_q;
      if (!enable) begin
         state_d  = CBT_ST_IDLE;
         cnt_d    = '0;
         synced_d = 1'b0;
      end else begin
         case (state_q)
            CBT_ST_IDLE: begin
               // start on a quantum boundary so the first sync slot is a full quantum
               if (tq_tick) begin // RULE4
                  state_d  = CBT_ST_SYNC;
                  cnt_d    = '0;
                  len_d    = `CBT_SYNC_TQ;
                  bs_d     = 1'b1;
                  tx_d     = tx_bit; // RULE10
                  synced_d = 1'b0;
               end
            end
            CBT_ST_SYNC: begin
               if (tq_tick) begin
                  // an edge inside the sync slot means we are already aligned
                  synced_d = synced_q | rx_fall;
                  state_d  = CBT_ST_SEG1; // RULE4
                  cnt_d    = '0;
                  len_d    = seg1_w; // RULE6
               end
            end
            CBT_ST_SEG1: begin
               if (tq_tick) begin
                  len_d = len_q;
                  if (rx_fall && !synced_q) begin
                     err      = pos;
                     adj      = min_q(err, sjw_w); // RULE14
                     len_d    = CNT_W'(len_q + adj); // RULE5 RULE8
                     synced_d = 1'b1;
                     rs_d     = 1'b1;
                     perr_d   = err;
                  end
                  if (pos >= len_d) begin
                     state_d = CBT_ST_SEG2;
                     cnt_d   = '0;
                     len_d   = seg2_w;
                     smp_d   = 1'b1;
                     rxb_d   = rx_in; // RULE9
                  end else begin
                     cnt_d = pos;
                  end
               end
            end
            CBT_ST_SEG2: begin
               if (tq_tick) begin
                  rem = (len_q > pos) ? CNT_W'(len_q - pos) : '0;
                  if (rx_fall && !synced_q && (rem != '0)) begin
                     err      = rem;
                     adj      = min_q(err, sjw_w); // RULE14
                     rem      = CNT_W'(rem - adj); // RULE7 RULE8
                     synced_d = 1'b1;
                     rs_d     = 1'b1;
                     perr_d   = err;
                  end
                  if (rem == '0) begin
                     state_d  = CBT_ST_SYNC; // RULE15
                     cnt_d    = '0;
                     len_d    = `CBT_SYNC_TQ;
                     bs_d     = 1'b1;
                     tx_d     = tx_bit; // RULE10
                     synced_d = 1'b0;
                  end else begin
                     cnt_d = pos;
                     len_d = CNT_W'(pos + rem);
                  end
               end
            end
            default: begin
               state_d = CBT_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q     <= CBT_ST_IDLE;
         cnt_q       <= '0;
         len_q       <= '0;
         synced_q    <= 1'b0;
         tx_out_q    <= `CBT_RECESSIVE;
         rx_bit_q    <= `CBT_RECESSIVE;
         sample_q    <= 1'b0;
         bit_start_q <= 1'b0;
         resync_q    <= 1'b0;
         phase_err_q <= '0;
      end else begin
         state_q     <= state_d;
         cnt_q       <= cnt_d;
         len_q       <= len_d;
         synced_q    <= synced_d;
         tx_out_q    <= tx_d;
         rx_bit_q    <= rxb_d;
         sample_q    <= smp_d;
         bit_start_q <= bs_d;
         resync_q    <= rs_d;
         phase_err_q <= perr_d;
      end
   end

   // configuration status: bit length in system clocks and legality
   always_comb begin
      clks_d = `CBT_CLKS_W'(({6'h00, cfg.brp} + 12'h001)
               * (12'(cfg.seg1) + 12'(cfg.seg2) + 12'(`CBT_SYNC_TQ))); // RULE1
      // the tolerance is tighter than one clock, so only an exact match passes
      rate_d  = (clks_d == `CBT_CLKS_W'(`CBT_NOM_CLKS)); // RULE2 RULE13
      // majority voting is never used; a triple request is only reported
      smode_d = CBT_SMP_SINGLE; // RULE11 RULE12
      cerr_d  = (cfg.smode == CBT_SMP_TRIPLE) || (cfg.seg1 == '0)
                || (cfg.seg2 < `CBT_SEG2_MIN) || (cfg.sjw == '0)
                || (cfg.sjw > cfg.seg2) || !rate_d;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bit_clks_q <= '0;
         rate_ok_q  <= 1'b0;
         smode_q    <= CBT_SMP_SINGLE;
         cfg_err_q  <= 1'b0;
      end else begin
         bit_clks_q <= clks_d;
         rate_ok_q  <= rate_d;
         smode_q    <= smode_d;
         cfg_err_q  <= cerr_d;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_sync_one_tq: assert property ( // RULE4
      (state_q == CBT_ST_SYNC && tq_tick && enable) |=> state_q == CBT_ST_SEG1)
      else $error("sync slot longer than one quantum");

   chk_seg1_lengthen: assert property ( // RULE5
      (state_q == CBT_ST_SEG1 && tq_tick && enable && rx_fall && !synced_q
       && cfg.sjw != '0)
      |=> resync_q && (len_q > $past(len_q)))
      else $error("early segment not lengthened on edge");

   chk_seg2_shorten: assert property ( // RULE7
      (state_q == CBT_ST_SEG2 && tq_tick && enable && rx_fall && !synced_q
       && len_q > pos && cfg.sjw != '0)
      |=> (state_q == CBT_ST_SYNC) || (len_q < $past(len_q)))
      else $error("late segment not shortened on edge");

   chk_jump_bound: assert property ( // RULE8 RULE14
      resync_q |-> phase_err_q >= $past(adj) && $past(adj) <= $past(sjw_w))
      else $error("adjustment beyond jump limit");

   chk_idle_wait: assert property ( // RULE4
      (state_q == CBT_ST_IDLE && !tq_tick) |=> state_q == CBT_ST_IDLE)
      else $error("bit started off a quantum boundary");

   chk_seg1_jump: assert property ( // RULE8 RULE14
      (resync_q && state_q == CBT_ST_SEG1)
      |-> CNT_W'(len_q - $past(len_q)) == ((phase_err_q < sjw_w) ? phase_err_q : sjw_w))
      else $error("early segment jump not clamped to limit");

   chk_seg2_jump: assert property ( // RULE7 RULE8 RULE14
      (resync_q && state_q == CBT_ST_SEG2)
      |-> CNT_W'($past(len_q) - len_q) == ((phase_err_q < sjw_w) ? phase_err_q : sjw_w))
      else $error("late segment jump not clamped to limit");

   chk_one_sample: assert property ( // RULE9
      sample_q |-> state_q == CBT_ST_SEG2 && $past(state_q) == CBT_ST_SEG1
                   && rx_bit_q == $past(rx_in))
      else $error("sample not at segment boundary");

   chk_tx_hold: assert property ( // RULE10
      $changed(tx_out_q) |-> bit_start_q && state_q == CBT_ST_SYNC)
      else $error("transmit bit changed mid-bit");

   chk_single_mode: assert property ( // RULE12
      smode_q == CBT_SMP_SINGLE ##1 (cfg.smode == CBT_SMP_TRIPLE) |=> cfg_err_q)
      else $error("triple sampling not refused");

   chk_rate_flag: assert property ( // RULE13
      !sys_rst |=> rate_ok_q == ($past(clks_d) == `CBT_CLKS_W'(`CBT_NOM_CLKS)))
      else $error("bit rate flag wrong");

   chk_next_sync: assert property ( // RULE15
      (state_q == CBT_ST_SEG2 && tq_tick && enable && pos >= len_q)
      |=> state_q == CBT_ST_SYNC && bit_start_q)
      else $error("sync slot not started after late segment");

endmodule

//--- sim/cbt_bus_node.sv
// behavioural far-side node that pulls the bus dominant once per bit
`timescale 1ns/1ps

module cbt_bus_node (
   input  wire logic       sys_clk,
   input  wire logic       bit_start,
   input  wire logic       arm,
   input  wire logic [5:0] dly,
   output logic            node_q
);
   int cnt = -1;

   initial node_q = 1'b1;

   // the pull is keyed to our bit start, so the phase error repeats every bit
   always @(posedge sys_clk) begin
      if (bit_start && arm)
         cnt <= 0;
      else if (cnt >= 0 && cnt < 63)
         cnt <= cnt + 1;
      else
         cnt <= -1;
      node_q <= !(cnt >= int'(dly) && cnt < int'(dly) + 16);
   end
endmodule

//--- sim/test_can_bit_timing_sync.sv
// self-checking bench for the bit-timing and synchronization block
`timescale 1ns/1ps
`include "cbt_params.svh"

module test_can_bit_timing_sync
   import cbt_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        enable  = 1'b0;
   cbt_cfg_s    cfg;
   logic        tx_bit  = 1'b1;
   logic        loop    = 1'b0;
   logic        arm     = 1'b0;
   logic [5:0]  dly     = 6'h0C;
   logic        node_q, tx_out_q, rx_bit_q, sample_q, bit_start_q, rate_ok_q, cfg_err_q;
   logic [11:0] bit_clks_q;
   cbt_smode_e  smode_q;
   logic        resync_q;
   logic [5:0]  phase_err_q;
   int          resyncs  = 0;
   int          m;
   logic [31:0] rnd;
   int          failures = 0;
   int          checks   = 0;
   int          n, s;
   logic        tx_exp, cur;
   wire         rx_in = loop ? (tx_out_q & node_q) : node_q;

   always #50 sys_clk = ~sys_clk;

   // resync pulses are counted so each measured bit can be held to one adjustment
   always @(posedge sys_clk) begin
      if (resync_q)
         resyncs <= resyncs + 1;
   end

   cbt_bit_timing i_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .enable(enable), .cfg(cfg),
      .tx_bit(tx_bit), .rx_in(rx_in), .tx_out_q(tx_out_q), .rx_bit_q(rx_bit_q),
      .sample_q(sample_q), .bit_start_q(bit_start_q), .resync_q(resync_q),
      .phase_err_q(phase_err_q),
      .smode_q(smode_q), .bit_clks_q(bit_clks_q), .rate_ok_q(rate_ok_q),
      .cfg_err_q(cfg_err_q));

   cbt_bus_node i_node (
      .sys_clk(sys_clk), .bit_start(bit_start_q), .arm(arm), .dly(dly), .node_q(node_q));

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // counts clocks up to the next start (0) or sample (1) pulse, gives up at 200
   task automatic wait_for(input bit which, output int cnt);
      cnt = 0;
      do begin
         @(negedge sys_clk);
         cnt++;
      end while (((which ? sample_q : bit_start_q) !== 1'b1) && cnt < 200);
   endtask

   function automatic logic [11:0] exp_clks(input cbt_cfg_s c);
      return (12'(c.brp) + 12'h001) * (12'h001 + 12'(c.seg1) + 12'(c.seg2));
   endfunction

   function automatic logic exp_err(input cbt_cfg_s c);
      return c.smode == CBT_SMP_TRIPLE || c.seg1 == 5'h00 || c.seg2 < `CBT_SEG2_MIN
         || c.sjw == 4'h0 || c.sjw > c.seg2 || exp_clks(c) != `CBT_NOM_CLKS;
   endfunction

   task automatic results();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #2000000;
      failures++;
      results();
   end

   initial begin
      cfg = '{6'h00, 5'h1E, 4'h9, 4'h2, CBT_SMP_SINGLE};
      void'($urandom(32'h4E1A7A40));
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // status over random settings, then jump limits 1..4 and a triple request
      for (int i = 0; i < 44; i++) begin
         @(posedge sys_clk);
         rnd = $urandom;
         if (i < 40)
            cfg <= rnd[$bits(cbt_cfg_s)-1:0];
         else
            cfg <= '{6'h00, 5'h1E, 4'h9, 4'(i - 39), cbt_smode_e'(i == 43)};
         repeat (2) @(negedge sys_clk);
         check(bit_clks_q, exp_clks(cfg));
         check(12'(rate_ok_q), 12'(exp_clks(cfg) == `CBT_NOM_CLKS));
         check(12'(cfg_err_q), 12'(exp_err(cfg)));
         check(12'(smode_q), 12'(CBT_SMP_SINGLE));
      end
      // 40 one-clock quanta: sample after 31, bit of 40; loopback in the second half
      @(posedge sys_clk);
      cfg <= '{6'h00, 5'h1E, 4'h9, 4'h2, CBT_SMP_SINGLE};
      tx_bit <= 1'b0;
      enable <= 1'b1;
      tx_exp = 1'b0;
      wait_for(1'b0, n);
      for (int b = 0; b < 24; b++) begin
         check(12'(tx_out_q), 12'(tx_exp));
         cur = tx_exp;
         @(posedge sys_clk);
         loop <= (b >= 12);
         tx_exp = 1'($urandom_range(1, 0));
         tx_bit <= tx_exp;
         wait_for(1'b1, s);
         if (!loop)
            check(12'(s), 12'h01F);
         check(12'(rx_bit_q), 12'(loop ? cur : 1'b1));
         wait_for(1'b0, n);
         if (!loop)
            check(12'(s + n), 12'h028);
      end
      // far node early then late in the bit; every jump is clamped to the limit
      @(posedge sys_clk);
      loop <= 1'b0;
      tx_bit <= 1'b1;
      arm <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         @(posedge sys_clk);
         cfg.sjw <= 4'(k % 3 + 1);
         dly <= (k < 3) ? 6'h0C : 6'h20;
         repeat (3) wait_for(1'b0, n);
         m = resyncs;
         wait_for(1'b0, n);
         check(12'(n), (k < 3) ? 12'(41 + k % 3) : 12'(39 - k % 3));
         check(12'(phase_err_q), (k < 3) ? 12'h00E : 12'h005);
         check(12'(resyncs - m), 12'h001);
      end
      // dropping enable mid-bit must stop further bits
      @(posedge sys_clk);
      arm <= 1'b0;
      enable <= 1'b0;
      wait_for(1'b0, n);
      check(12'(n), 12'h0C8);
      // four-clock quanta from idle: sample after 7 quanta, bit of 10 quanta
      @(posedge sys_clk);
      cfg <= '{6'h03, 5'h06, 4'h3, 4'h2, CBT_SMP_SINGLE};
      tx_bit <= 1'b0;
      enable <= 1'b1;
      wait_for(1'b0, n);
      check(12'(tx_out_q), 12'h000);
      wait_for(1'b1, s);
      check(12'(s), 12'h01C);
      check(12'(rx_bit_q), 12'h001);
      check(12'(rate_ok_q), 12'h001);
      wait_for(1'b0, n);
      check(12'(s + n), exp_clks(cfg));
      results();
   end
endmodule
